// *** design/ipmc_ctrl.sv ***
`timescale 1ns/1ps
module ipmc_ctrl (
  // clock and reset
  input  wire logic                  CLK,
  input  wire logic                  SRST,
  // register port
  input  wire logic [2:0]            ADDR,
  input  wire logic [7:0]            WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic [7:0]                 RDATA,
  // core decode and fetch
  input  wire ipmc_pkg::ipmc_instr_t INSTR,
  output ipmc_pkg::ipmc_vec_t        VEC,
  output logic                       INST_TICK,
  output logic                       GLOBAL_IRQ_ENABLE,
  // event sources
  input  wire logic                  TMR_OVF,
  input  wire logic [5:0]            PIN_IN,
  input  wire logic [5:0]            PIN_IS_IN,
  // configuration words
  input  wire logic                  CFG_START_HIGH,
  input  wire logic                  CFG_DIV4,
  input  wire logic [2:0]            CFG_HRC_FREQ,
  // power and clocks
  output ipmc_pkg::ipmc_clk_t        CLKS,
  output ipmc_pkg::ipmc_mode_t       MODE,
  output logic [2:0]                 HRC_FREQ,
  output logic                       WDT_CLR
);
  import ipmc_pkg::*;

  logic [2:0]  irq_flag_register_q;
  logic [2:0]  irq_enable_register_q;
  logic        gie_q;
  logic        timer_run_enable_q;
  logic        hsel_q;
  logic        hstop_q;
  logic        pd_q;
  logic        to_q;
  logic [5:0]  wsel_q;
  logic        eis_q;
  logic        edge_q;
  ipmc_mode_t  mode_q;
  ipmc_mode_t  mode_d;
  logic [3:0]  stab_q;
  ipmc_vec_t   vec_q;
  ipmc_clk_t   clk_q;
  logic [7:0]  rdata_q;
  logic [2:0]  hrc_q;
  logic        wdt_clr_q;
  logic [5:0]  chg;
  logic [5:0]  rise;
  logic [5:0]  fall;
  logic [5:0]  pin_mask;
  logic        pin_evt;
  logic        ext_evt;
  logic        tmr_evt;
  logic [2:0]  evt;
  logic [2:0]  masked;
  logic        running;
  logic        sw_take;
  logic        hw_take;
  logic        wr_irq_flag_register;
  logic        wr_osc;
  logic [1:0]  operating_mode_field_wr;
  logic [1:0]  operating_mode_field_rd;
  ipmc_mode_t  run_mode;

  //////////////////////////////////////////////////////////////////////////////
  // decode

  assign wr_irq_flag_register  = WR && (ADDR == OFS_IRQ_FLAG_REGISTER);
  assign wr_osc   = WR && (ADDR == OFS_OSC);
  assign operating_mode_field_wr  = WDATA[OPERATING_MODE_FIELD_LO+1:OPERATING_MODE_FIELD_LO];
  assign running  = (mode_q == M_NORMAL) || (mode_q == M_SLOW);
  assign run_mode = hsel_q ? M_NORMAL : M_SLOW;

  //////////////////////////////////////////////////////////////////////////////
  // event sources

  // one watcher per port pin
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_pin
      ipmc_pin_watch u_watch (
        .clk  (CLK),
        .srst (SRST),
        .pin  (PIN_IN[g]),
        .chg  (chg[g]),
        .rise (rise[g]),
        .fall (fall[g])
      );
    end
  endgenerate

  // pin 0 change is handed to the external interrupt when selected
  assign pin_mask = PIN_IS_IN & wsel_q & ~{5'h00, eis_q};
  assign pin_evt  = |(chg & pin_mask);
  assign ext_evt  = eis_q && (edge_q ? rise[0] : fall[0]);
  // timer is off in halt and while oscillators settle
  assign tmr_evt  = TMR_OVF && (mode_q != M_HALT) && (mode_q != M_STABLE);
  assign evt      = {ext_evt, pin_evt, tmr_evt};

  //////////////////////////////////////////////////////////////////////////////
  // flags and enables

  // event set wins over a software clear in the same cycle
  always_ff @(posedge CLK)
  begin
    if (SRST)
      irq_flag_register_q <= FLAG_RST;
    else
      irq_flag_register_q <= (wr_irq_flag_register ? (irq_flag_register_q & WDATA[2:0]) : irq_flag_register_q) | evt;
  end

  // per-source enables, pin wake selects and external control
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      irq_enable_register_q <= IRQ_ENABLE_REGISTER_RST;
      wsel_q <= WAKE_RST;
      eis_q  <= 1'b0;
      edge_q <= 1'b0;
      timer_run_enable_q <= 1'b0;
    end
    else
    begin
      if (WR && ADDR == OFS_IRQ_ENABLE_REGISTER)
        irq_enable_register_q <= WDATA[2:0];
      if (WR && ADDR == OFS_WAKE)
        wsel_q <= WDATA[5:0];
      if (WR && ADDR == OFS_EXT)
      begin
        eis_q  <= WDATA[EIS_BIT];
        edge_q <= WDATA[EDGE_BIT];
      end
      if (WR && ADDR == OFS_SECOND_POWER_CONTROL_REGISTER)
        timer_run_enable_q <= WDATA[TIMER_RUN_ENABLE_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // vectoring and global enable

  // all hardware sources share one vector; software polls the flags
  assign masked  = irq_flag_register_q & irq_enable_register_q;
  assign sw_take = running && INSTR.swi;
  assign hw_take = running && gie_q && (|masked) && !INSTR.swi;

  // a taken vector always clears the enable to block nesting
  always_ff @(posedge CLK)
  begin
    if (SRST)
      gie_q <= 1'b0;
    else if (sw_take || hw_take)
      gie_q <= 1'b0;
    else if (INSTR.enable_irq_instruction || INSTR.return_from_isr_instruction)
      gie_q <= 1'b1;
    else if (INSTR.disable_irq_instruction)
      gie_q <= 1'b0;
    else if (WR && ADDR == OFS_SECOND_POWER_CONTROL_REGISTER)
      gie_q <= WDATA[GIE_BIT];
  end

  // redirect pulse to the fetch unit; wake with enable lands here too
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      vec_q.req  <= 1'b0;
      vec_q.addr <= SW_VEC;
    end
    else
    begin
      vec_q.req  <= sw_take || hw_take;
      vec_q.addr <= sw_take ? SW_VEC : HW_VEC;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // oscillator control

  // stop bit is only ever changed by software, never by a mode change
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      hsel_q  <= CFG_START_HIGH;
      hstop_q <= 1'b0;
    end
    else if (wr_osc)
    begin
      hsel_q  <= WDATA[SEL_BIT];
      hstop_q <= WDATA[STOP_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // operating mode

  // software must slow down before stopping the fast oscillator; not checked
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      M_NORMAL, M_SLOW:
      begin
        if (INSTR.sleep || (wr_osc && operating_mode_field_wr == OPERATING_MODE_FIELD_HALT))
          mode_d = M_HALT;
        else if (wr_osc && operating_mode_field_wr == OPERATING_MODE_FIELD_STBY)
          mode_d = M_STANDBY;
        else if (wr_osc)
          mode_d = WDATA[SEL_BIT] ? M_NORMAL : M_SLOW;
      end
      M_STANDBY:
      begin
        if (|evt)
          mode_d = run_mode;
      end
      M_HALT:
      begin
        if (pin_evt || ext_evt)
          mode_d = M_STABLE;
      end
      M_STABLE:
      begin
        if (stab_q == STABLE_LAST)
          mode_d = run_mode;
      end
      default:
        mode_d = M_NORMAL;
    endcase
  end

  // start mode comes from the startup clock configuration
  always_ff @(posedge CLK)
  begin
    if (SRST)
      mode_q <= CFG_START_HIGH ? M_NORMAL : M_SLOW;
    else
      mode_q <= mode_d;
  end

  // settle counter for oscillator restart after halt
  always_ff @(posedge CLK)
  begin
    if (SRST || mode_q != M_STABLE)
      stab_q <= 4'h0;
    else
      stab_q <= stab_q + 4'h1;
  end

  // status bits and watchdog clear on halt entry
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      pd_q      <= PD_RST;
      to_q      <= TO_RST;
      wdt_clr_q <= 1'b0;
    end
    else
    begin
      wdt_clr_q <= 1'b0;
      if (mode_d == M_HALT && mode_q != M_HALT)
      begin
        pd_q      <= 1'b0;
        to_q      <= 1'b1;
        wdt_clr_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock enables and instruction clock

  // one cycle behind the mode register
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      clk_q <= '0;
      hrc_q <= HRC_20M;
    end
    else
    begin
      clk_q.hosc_en   <= !hstop_q && mode_q != M_HALT;
      clk_q.losc_en   <= mode_q != M_HALT;
      clk_q.sel_high  <= hsel_q;
      clk_q.cpu_run   <= running;
      clk_q.periph_en <= mode_q != M_HALT && mode_q != M_STABLE;
      clk_q.timer_run <= timer_run_enable_q && mode_q != M_HALT && mode_q != M_STABLE;
      // unsupported codes fall back to the top setting
      hrc_q <= (CFG_HRC_FREQ > HRC_20M) ? HRC_20M : CFG_HRC_FREQ;
    end
  end

  ipmc_clk_div u_div (
    .clk  (CLK),
    .srst (SRST),
    .run  (running),
    .div4 (CFG_DIV4),
    .tick (INST_TICK)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register readback

  assign operating_mode_field_rd = (mode_q == M_STANDBY) ? OPERATING_MODE_FIELD_STBY :
                   (mode_q == M_HALT) ? OPERATING_MODE_FIELD_HALT : OPERATING_MODE_FIELD_RUN;

  // data valid only in the cycle after the read strobe
  always_ff @(posedge CLK)
  begin
    if (SRST || !RD)
      rdata_q <= 8'h00;
    else
    begin
      case (ADDR)
        OFS_IRQ_FLAG_REGISTER:  rdata_q <= {5'h00, masked};
        OFS_IRQ_ENABLE_REGISTER:  rdata_q <= {5'h00, irq_enable_register_q};
        OFS_SECOND_POWER_CONTROL_REGISTER: rdata_q <= {gie_q, 6'h00, timer_run_enable_q};
        OFS_OSC:   rdata_q <= {4'h0, operating_mode_field_rd, hstop_q, hsel_q};
        OFS_STAT:  rdata_q <= {3'h0, to_q, pd_q, 3'h0};
        OFS_WAKE:  rdata_q <= {2'h0, wsel_q};
        OFS_EXT:   rdata_q <= {6'h00, edge_q, eis_q};
        default:   rdata_q <= 8'h00;
      endcase
    end
  end

  assign RDATA    = rdata_q;
  assign VEC      = vec_q;
  assign GLOBAL_IRQ_ENABLE      = gie_q;
  assign CLKS     = clk_q;
  assign MODE     = mode_q;
  assign HRC_FREQ = hrc_q;
  assign WDT_CLR  = wdt_clr_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  a_swi_vector: assert property (
    sw_take |=> VEC.req && VEC.addr == SW_VEC && !gie_q)
    else $error("software interrupt did not vector");

  a_eni_sets: assert property (
    INSTR.enable_irq_instruction && !sw_take && !hw_take |=> gie_q)
    else $error("enable instruction did not set global enable");

  a_return_from_isr_instruction_sets: assert property (
    INSTR.return_from_isr_instruction && !sw_take && !hw_take |=> gie_q)
    else $error("return did not set global enable");

  a_flag_sticky: assert property (
    $fell(irq_flag_register_q[FLG_TMR]) |-> $past(wr_irq_flag_register) && !$past(WDATA[FLG_TMR]))
    else $error("timer flag cleared without a write of 0");

  a_flag_read: assert property (
    RD && ADDR == OFS_IRQ_FLAG_REGISTER |=> RDATA == {5'h00, $past(masked)})
    else $error("flag read not gated by enables");

  a_hw_vector: assert property (
    running && gie_q && (|masked) && !INSTR.swi |=> VEC.req && VEC.addr == HW_VEC && !gie_q)
    else $error("hardware interrupt did not vector");

  a_pb0_masked: assert property (
    eis_q && !wr_irq_flag_register && !irq_flag_register_q[FLG_PIN] && (chg[5:1] & pin_mask[5:1]) == 5'h00
      |=> !irq_flag_register_q[FLG_PIN])
    else $error("pin 0 change set flag under external select");

  a_halt_entry: assert property (
    mode_q == M_HALT && $past(mode_q) != M_HALT |-> !pd_q && to_q && wdt_clr_q)
    else $error("halt entry status wrong");

  a_halt_osc_off: assert property (
    mode_q == M_HALT ##1 mode_q == M_HALT |-> !CLKS.hosc_en && !CLKS.losc_en)
    else $error("oscillators running in halt");

  a_halt_wait: assert property (
    mode_q == M_HALT ##1 mode_q == M_STABLE |-> ##15 mode_q == M_STABLE ##1 running)
    else $error("halt wake did not wait 16 cycles");

  a_standby_wake: assert property (
    mode_q == M_STANDBY && tmr_evt |=> mode_q == run_mode)
    else $error("standby did not wake on timer");

endmodule // ipmc_ctrl

// *** design/ipmc_pkg.sv ***
// Overview of operation
// - software interrupt vectors to 0x001, clears enable
// - enable/disable instructions set/clear global enable
// - return-from-interrupt sets global enable, resumes
// - hardware events set sticky flags, write 0 clears
// - flag reads only where its enable is 1
// - pending enabled flag with enable vectors 0x008
// - timer overflow sets timer flag
// - selected input pin change sets pin flag
// - external select disables pin 0 change detection
// - chosen edge on pin 0 sets external flag
// - select bit picks high or low oscillator
// - instruction clock is system clock over 2/4
// - fast rc frequency chosen by configuration
// - reset start mode follows startup clock choice
// - mode field 10b enters standby
// - high oscillator stops by stop bit or in halt
// - timer, pin or external event wakes standby
// - wake resumes normal or slow per select
// - halt entry clears power-down, sets timeout, clears watchdog
// - halt stops clocks, only pin/external wake
// - stop bit and halt in one write
// - global enable at bit 7 of power control
// - wake with enable set branches to vector
// - halt wake waits 16 system clocks
package ipmc_pkg;

  // register offsets on the plain register port
  localparam logic [2:0] OFS_IRQ_FLAG_REGISTER  = 3'h0;
  localparam logic [2:0] OFS_IRQ_ENABLE_REGISTER  = 3'h1;
  localparam logic [2:0] OFS_SECOND_POWER_CONTROL_REGISTER = 3'h2;
  localparam logic [2:0] OFS_OSC   = 3'h3;
  localparam logic [2:0] OFS_STAT  = 3'h4;
  localparam logic [2:0] OFS_WAKE  = 3'h5;
  localparam logic [2:0] OFS_EXT   = 3'h6;

  // field positions
  localparam int FLG_TMR   = 0;
  localparam int FLG_PIN   = 1;
  localparam int FLG_EXT   = 2;
  localparam int GIE_BIT   = 7;
  localparam int TIMER_RUN_ENABLE_BIT  = 0;
  localparam int SEL_BIT   = 0;
  localparam int STOP_BIT  = 1;
  localparam int OPERATING_MODE_FIELD_LO   = 2;
  localparam int PD_BIT    = 3;
  localparam int TO_BIT    = 4;
  localparam int EIS_BIT   = 0;
  localparam int EDGE_BIT  = 1;

  // mode field codes
  localparam logic [1:0] OPERATING_MODE_FIELD_RUN  = 2'h0;
  localparam logic [1:0] OPERATING_MODE_FIELD_HALT = 2'h1;
  localparam logic [1:0] OPERATING_MODE_FIELD_STBY = 2'h2;

  // vectors
  localparam logic [8:0] SW_VEC = 9'h001;
  localparam logic [8:0] HW_VEC = 9'h008;

  // reset values
  localparam logic [2:0] FLAG_RST = 3'h0;
  localparam logic [2:0] IRQ_ENABLE_REGISTER_RST = 3'h0;
  localparam logic [5:0] WAKE_RST = 6'h00;
  localparam logic       PD_RST   = 1'b1;
  localparam logic       TO_RST   = 1'b1;

  // timing and clocking
  localparam int         CLK_HZ       = 10_000_000;
  localparam logic [3:0] STABLE_LAST  = 4'hf;  // 16 system clocks
  localparam logic [1:0] DIV2_LAST    = 2'h1;
  localparam logic [1:0] DIV4_LAST    = 2'h3;
  localparam int         LRC_HZ       = 32768;
  localparam logic [2:0] HRC_1M       = 3'h0;
  localparam logic [2:0] HRC_20M      = 3'h5;

  // decoded instruction strobes from the core, one cycle each
  typedef struct packed {
    logic swi;
    logic enable_irq_instruction;
    logic disable_irq_instruction;
    logic return_from_isr_instruction;
    logic sleep;
  } ipmc_instr_t;

  // fetch redirect to the core
  typedef struct packed {
    logic       req;
    logic [8:0] addr;
  } ipmc_vec_t;

  // clock and power enables
  typedef struct packed {
    logic hosc_en;
    logic losc_en;
    logic sel_high;
    logic cpu_run;
    logic periph_en;
    logic timer_run;
  } ipmc_clk_t;

  typedef enum logic [4:0] {
    M_NORMAL  = 5'h01,
    M_SLOW    = 5'h02,
    M_STANDBY = 5'h04,
    M_HALT    = 5'h08,
    M_STABLE  = 5'h10
  } ipmc_mode_t;

endpackage

// *** design/ipmc_pin_watch.sv ***
`timescale 1ns/1ps
// level change and edge detection on one synchronous pin
module ipmc_pin_watch (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // pin
  input  wire logic pin,
  // events
  output logic      chg,
  output logic      rise,
  output logic      fall
);
  logic prev_q;

  // previous level; loads the live level at reset so no false change
  always_ff @(posedge clk)
  begin
    prev_q <= pin;
  end

  assign chg  = pin ^ prev_q;
  assign rise = pin & ~prev_q;
  assign fall = ~pin & prev_q;
endmodule // ipmc_pin_watch

// *** design/ipmc_clk_div.sv ***
`timescale 1ns/1ps
// instruction clock tick from the system clock
module ipmc_clk_div
  import ipmc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // control
  input  wire logic run,
  input  wire logic div4,
  // tick
  output logic      tick
);
  logic [1:0] cnt_q;
  logic [1:0] last;

  assign last = div4 ? DIV4_LAST : DIV2_LAST;

  // counter held at zero while execution is stopped
  always_ff @(posedge clk)
  begin
    if (srst || !run)
    begin
      cnt_q <= 2'h0;
      tick  <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q == last) ? 2'h0 : cnt_q + 2'h1;
      tick  <= (cnt_q == last);
    end
  end
endmodule // ipmc_clk_div

// *** sim/ipmc_core_model.sv ***
`timescale 1ns/1ps
// core fetch side and port pins facing the controller
module ipmc_core_model (
  // clock
  input  wire logic                clk,
  // fetch redirect in, decoded strobes out
  input  wire ipmc_pkg::ipmc_vec_t vec,
  output ipmc_pkg::ipmc_instr_t    instr,
  // port pin levels
  output logic [5:0]               pins
);
  import ipmc_pkg::*;

  int unsigned n_vec;
  logic [8:0]  last_vec;

  // idle core, pins low so the reset baseline is known
  initial
  begin
    instr    = '0;
    pins     = 6'h00;
    n_vec    = 0;
    last_vec = 9'h000;
  end

  ////////////////////////////////////////////////////////////
  // one strobe for exactly one cycle, never two at once
  task automatic issue(input ipmc_instr_t i);
    @(posedge clk);
    instr <= i;
    @(posedge clk);
    instr <= '0;
    #1;
  endtask

  // flip one pin just after an edge
  task automatic toggle(input int p);
    @(posedge clk);
    pins[p] <= ~pins[p];
    #1;
  endtask

  // the core follows every redirect; counted for the bench
  always @(posedge clk)
  begin
    if (vec.req === 1'b1)
    begin
      n_vec    <= n_vec + 1;
      last_vec <= vec.addr;
    end
  end

endmodule // ipmc_core_model

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import ipmc_pkg::*;

  logic        clk;
  logic        srst;
  logic [2:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  ipmc_instr_t instr;
  ipmc_vec_t   vec;
  logic        inst_tick;
  logic        global_irq_enable;
  logic        tmr_ovf;
  logic [5:0]  pin_in;
  logic [5:0]  pin_is_in;
  logic        start_high;
  logic        div4;
  logic [2:0]  hrc_cfg;
  ipmc_clk_t   clks;
  ipmc_mode_t  mode;
  logic [2:0]  hrc_freq;
  logic        wdt_clr;
  int          error_cnt;
  int          n_compared;
  int unsigned v0;
  int          n;
  int          p;
  int          q;
  logic [7:0]  d;
  ipmc_instr_t seq_i [5] = '{5'h08, 5'h10, 5'h02, 5'h04, 5'h10};
  logic        seq_g [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  ipmc_ctrl ipmc_ctrl_inst (
    .CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .INSTR(instr), .VEC(vec), .INST_TICK(inst_tick), .GLOBAL_IRQ_ENABLE(global_irq_enable),
    .TMR_OVF(tmr_ovf), .PIN_IN(pin_in), .PIN_IS_IN(pin_is_in),
    .CFG_START_HIGH(start_high), .CFG_DIV4(div4), .CFG_HRC_FREQ(hrc_cfg),
    .CLKS(clks), .MODE(mode), .HRC_FREQ(hrc_freq), .WDT_CLR(wdt_clr)
  );

  ipmc_core_model ipmc_core_model_inst (
    .clk(clk), .vec(vec), .instr(instr), .pins(pin_in)
  );

  // 10 mhz system clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////
  // expectations
  function automatic logic [2:0] exp_hrc(input logic [2:0] c);
    return (c > HRC_20M) ? HRC_20M : c;
  endfunction

  function automatic int exp_ticks(input logic d4, input int cyc);
    return cyc / (d4 ? 4 : 2);
  endfunction

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // register port: one-cycle strobes, read data the cycle after
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic pulse_tmr();
    @(posedge clk);
    tmr_ovf <= 1'b1;
    @(posedge clk);
    tmr_ovf <= 1'b0;
    #1;
  endtask

  task automatic do_reset(input logic hi);
    @(posedge clk);
    srst       <= 1'b1;
    start_high <= hi;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    tick(2);
  endtask

  // wait for the halt wake to start, then measure how long it settles
  task automatic settle(output int cnt);
    cnt = 0;
    for (int k = 0; k < 6 && mode !== M_STABLE; k++)
      tick(1);
    while (mode === M_STABLE && cnt < 40)
    begin
      tick(1);
      cnt++;
    end
  endtask

  ////////////////////////////////////////////////////////////
  // hang guard; the whole run is well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    summarize();
  end

  initial
  begin
    addr       = 3'h0;
    wdata      = 8'h00;
    wr         = 1'b0;
    rd         = 1'b0;
    srst       = 1'b1;
    tmr_ovf    = 1'b0;
    pin_is_in  = 6'h3f;
    start_high = 1'b0;
    error_cnt  = 0;
    n_compared = 0;
    v0         = $urandom(34592);
    div4       = 1'($urandom_range(1));
    hrc_cfg    = 3'($urandom_range(7));
    do_reset(1'b0);
    chk("start mode low", mode, M_SLOW);
    do_reset(1'b1);
    chk("start mode high", mode, M_NORMAL);
    chk("fast rc code", hrc_freq, exp_hrc(hrc_cfg));
    rd_reg(OFS_STAT, d);
    chk("status reset", d, 8'h18);
    rd_reg(3'h7, d);
    chk("unmapped read", d, 8'h00);
    n = 0;
    // 40 cycles is a multiple of both divisors, so phase does not matter
    repeat (40)
    begin
      tick(1);
      if (inst_tick === 1'b1)
        n++;
    end
    chk("instr ticks", 16'(n), 16'(exp_ticks(div4, 40)));
    // enable, software vector, return, disable, software vector again
    for (int k = 0; k < 5; k++)
    begin
      ipmc_core_model_inst.issue(seq_i[k]);
      chk("gie", global_irq_enable, seq_g[k]);
      chk("vector", {vec.req, vec.req ? vec.addr : 9'h000},
          (seq_i[k] == 5'h10) ? 10'h201 : 10'h000);
    end
    // timer flag: masked read, sticky, hardware vector
    wr_reg(OFS_IRQ_ENABLE_REGISTER, 8'h00);
    pulse_tmr();
    rd_reg(OFS_IRQ_FLAG_REGISTER, d);
    chk("flags masked", d, 8'h00);
    wr_reg(OFS_IRQ_ENABLE_REGISTER, 8'h01);
    wr_reg(OFS_IRQ_FLAG_REGISTER, 8'h01);
    rd_reg(OFS_IRQ_FLAG_REGISTER, d);
    chk("timer flag", d, 8'h01);
    v0 = ipmc_core_model_inst.n_vec;
    wr_reg(OFS_SECOND_POWER_CONTROL_REGISTER, 8'h80);
    tick(3);
    chk("hw vector count", 16'(ipmc_core_model_inst.n_vec - v0), 16'h1);
    chk("hw vector addr", ipmc_core_model_inst.last_vec, HW_VEC);
    chk("gie after hw", global_irq_enable, 1'b0);
    wr_reg(OFS_IRQ_FLAG_REGISTER, 8'h00);
    rd_reg(OFS_IRQ_FLAG_REGISTER, d);
    chk("flag cleared", d, 8'h00);
    // pin change: an output pin is ignored, an input pin flags
    p = $urandom_range(5, 1);
    q = (p % 5) + 1;
    @(posedge clk);
    pin_is_in <= 6'h3f ^ (6'h01 << q);
    wr_reg(OFS_WAKE, 8'h3f);
    wr_reg(OFS_IRQ_ENABLE_REGISTER, 8'h07);
    ipmc_core_model_inst.toggle(q);
    tick(2);
    rd_reg(OFS_IRQ_FLAG_REGISTER, d);
    chk("output pin change", d, 8'h00);
    ipmc_core_model_inst.toggle(p);
    tick(2);
    rd_reg(OFS_IRQ_FLAG_REGISTER, d);
    chk("input pin change", d, 8'h02);
    wr_reg(OFS_IRQ_FLAG_REGISTER, 8'h00);
    // slow first, stop the fast oscillator afterwards
    wr_reg(OFS_OSC, 8'h00);
    tick(2);
    chk("slow mode", mode, M_SLOW);
    chk("slow clocks", {clks.sel_high, clks.hosc_en}, 2'h1);
    wr_reg(OFS_OSC, 8'h02);
    tick(2);
    chk("fast stopped", clks.hosc_en, 1'b0);
    wr_reg(OFS_OSC, 8'h01);
    tick(2);
    chk("normal mode", mode, M_NORMAL);
    // standby, timer wake with global enable set
    wr_reg(OFS_IRQ_ENABLE_REGISTER, 8'h01);
    wr_reg(OFS_SECOND_POWER_CONTROL_REGISTER, 8'h81);
    v0 = ipmc_core_model_inst.n_vec;
    wr_reg(OFS_OSC, 8'h09);
    tick(2);
    chk("standby mode", mode, M_STANDBY);
    chk("standby clocks", {clks.cpu_run, clks.losc_en, clks.timer_run, clks.hosc_en},
        4'h7);
    pulse_tmr();
    chk("standby wake", mode, M_NORMAL);
    tick(3);
    chk("wake vector count", 16'(ipmc_core_model_inst.n_vec - v0), 16'h1);
    chk("wake vector addr", 16'(ipmc_core_model_inst.last_vec), 16'(HW_VEC));
    wr_reg(OFS_IRQ_FLAG_REGISTER, 8'h00);
    // halt by write together with the stop bit, select low
    v0 = ipmc_core_model_inst.n_vec;
    wr_reg(OFS_OSC, 8'h06);
    chk("halt mode", mode, M_HALT);
    chk("watchdog clear", wdt_clr, 1'b1);
    tick(2);
    chk("halt clocks", {clks.hosc_en, clks.losc_en, clks.periph_en, clks.timer_run},
        4'h0);
    pulse_tmr();
    tick(2);
    chk("timer no wake", mode, M_HALT);
    ipmc_core_model_inst.toggle(p);
    settle(n);
    chk("halt settle", 16'(n), 16'd16);
    chk("halt wake mode", mode, M_SLOW);
    chk("no vector", 16'(ipmc_core_model_inst.n_vec - v0), 16'h0);
    rd_reg(OFS_STAT, d);
    chk("status halt", d, 8'h10);
    // sleep, external rising edge on pin 0 wakes; pin and external reads enabled
    wr_reg(OFS_IRQ_FLAG_REGISTER, 8'h00);
    wr_reg(OFS_IRQ_ENABLE_REGISTER, 8'h06);
    wr_reg(OFS_EXT, 8'h03);
    ipmc_core_model_inst.issue(5'h01);
    chk("sleep halt", mode, M_HALT);
    ipmc_core_model_inst.toggle(0);
    settle(n);
    chk("ext wake", mode, M_SLOW);
    rd_reg(OFS_IRQ_FLAG_REGISTER, d);
    chk("ext flag only", d, 8'h04);
    // falling edge selected
    wr_reg(OFS_IRQ_FLAG_REGISTER, 8'h00);
    wr_reg(OFS_EXT, 8'h01);
    ipmc_core_model_inst.toggle(0);
    tick(2);
    rd_reg(OFS_IRQ_FLAG_REGISTER, d);
    chk("ext falling", d, 8'h04);
    summarize();
  end

endmodule // testbench
